// ===== hdl/dual_pll_serial_program_latches.sv
// Serial programming latches, dividers, pump control and status pin of a dual-loop synthesizer
`timescale 1ns/1ps
module dual_pll_serial_program_latches #(
   parameter int WORD_W = synth_prog_pkg::WORD_W
) (
   input  wire logic                          i_mclk,
   input  wire logic                          i_nrst,
   input  wire logic                          i_serial_clk,
   input  wire logic                          i_serial_data,
   input  wire logic                          i_load_strobe,
   input  wire logic                          i_ref_osc,
   input  wire logic [synth_prog_pkg::NUM_LOOPS-1:0] i_fb_in,
   output logic      [synth_prog_pkg::NUM_LOOPS-1:0] o_pump_up,
   output logic      [synth_prog_pkg::NUM_LOOPS-1:0] o_pump_dn,
   output logic      [synth_prog_pkg::NUM_LOOPS-1:0] o_pump_hiz,
   output logic      [synth_prog_pkg::NUM_LOOPS-1:0] o_pump_high,
   output logic      [synth_prog_pkg::NUM_LOOPS-1:0] o_modulus_128,
   output logic      [synth_prog_pkg::NUM_LOOPS-1:0] o_power_down,
   output logic                               o_osc_enable,
   output logic                               o_shared_status_pin,
   output logic                               o_shared_status_oe_n
);

   localparam int NL = synth_prog_pkg::NUM_LOOPS;
   localparam int DW = synth_prog_pkg::DATA_W;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic          sclk_rise;
   logic          sdata_lvl;
   logic          load_rise;
   logic          osc_rise;
   logic [NL-1:0] fb_rise;

   pin_sync u_sync_sclk (
      .i_mclk  (i_mclk),
      .i_nrst  (i_nrst),
      .i_pin   (i_serial_clk),
      .o_level (),
      .o_rise  (sclk_rise)
   );

   pin_sync u_sync_sdata (
      .i_mclk  (i_mclk),
      .i_nrst  (i_nrst),
      .i_pin   (i_serial_data),
      .o_level (sdata_lvl),
      .o_rise  ()
   );

   pin_sync u_sync_load (
      .i_mclk  (i_mclk),
      .i_nrst  (i_nrst),
      .i_pin   (i_load_strobe),
      .o_level (),
      .o_rise  (load_rise)
   );

   pin_sync u_sync_osc (
      .i_mclk  (i_mclk),
      .i_nrst  (i_nrst),
      .i_pin   (i_ref_osc),
      .o_level (),
      .o_rise  (osc_rise)
   );

   for (genvar g = 0; g < NL; g++) begin : g_fb_sync
      pin_sync u_sync_fb (
         .i_mclk  (i_mclk),
         .i_nrst  (i_nrst),
         .i_pin   (i_fb_in[g]),
         .o_level (),
         .o_rise  (fb_rise[g])
      );
   end

   // ---------------------------------------------------------------
   // Shift register and latches
   // ---------------------------------------------------------------
   // Data and clock pass the same synchroniser depth, so the sampled data
   // bit is the one that stood at the clock edge given the setup time.
   logic [WORD_W-1:0] shift_q;
   logic [WORD_W-1:0] shift_d;
   logic [DW-1:0]     ref_latch_q [NL];
   logic [DW-1:0]     ref_latch_d [NL];
   logic [DW-1:0]     fb_latch_q  [NL];
   logic [DW-1:0]     fb_latch_d  [NL];
   logic [1:0]        sel;
   logic [DW-1:0]     word_data;

   assign sel       = {shift_q[synth_prog_pkg::SEL_HI_POS], shift_q[synth_prog_pkg::SEL_LO_POS]};
   assign word_data = shift_q[synth_prog_pkg::DATA_LSB +: DW];

   always_comb begin
      shift_d = shift_q;
      if (sclk_rise) begin
         shift_d = {shift_q[WORD_W-2:0], sdata_lvl};
      end
      for (int i = 0; i < NL; i++) begin
         ref_latch_d[i] = ref_latch_q[i];
         fb_latch_d[i]  = fb_latch_q[i];
      end
      // Only the strobe edge updates a latch; shifting alone leaves them
      if (load_rise) begin
         unique case (sel)
            synth_prog_pkg::SEL_SECOND_REF: ref_latch_d[synth_prog_pkg::SECOND_LOOP] = word_data;
            synth_prog_pkg::SEL_FIRST_REF:  ref_latch_d[synth_prog_pkg::FIRST_LOOP]  = word_data;
            synth_prog_pkg::SEL_SECOND_FB:  fb_latch_d[synth_prog_pkg::SECOND_LOOP]  = word_data;
            synth_prog_pkg::SEL_FIRST_FB:   fb_latch_d[synth_prog_pkg::FIRST_LOOP]   = word_data;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         shift_q <= '0;
         for (int i = 0; i < NL; i++) begin
            ref_latch_q[i] <= synth_prog_pkg::LATCH_RESET;
            fb_latch_q[i]  <= synth_prog_pkg::LATCH_RESET;
         end
      end else begin
         shift_q <= shift_d;
         for (int i = 0; i < NL; i++) begin
            ref_latch_q[i] <= ref_latch_d[i];
            fb_latch_q[i]  <= fb_latch_d[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   synth_prog_pkg::loop_cfg_t cfg [NL];

   always_comb begin
      for (int i = 0; i < NL; i++) begin
         cfg[i].ref_ratio          = ref_latch_q[i][synth_prog_pkg::REF_RATIO_LSB +: synth_prog_pkg::REF_RATIO_W];
         cfg[i].phase_polarity_bit = ref_latch_q[i][synth_prog_pkg::POLARITY_POS];
         cfg[i].pump_level_bit     = ref_latch_q[i][synth_prog_pkg::LEVEL_POS];
         cfg[i].pump_hiz_bit       = ref_latch_q[i][synth_prog_pkg::HIZ_POS];
         cfg[i].lock_indicate_bit  = ref_latch_q[i][synth_prog_pkg::LOCK_SEL_POS];
         cfg[i].divider_view_bit   = ref_latch_q[i][synth_prog_pkg::VIEW_SEL_POS];
         cfg[i].swallow            = fb_latch_q[i][synth_prog_pkg::SWALLOW_LSB +: synth_prog_pkg::SWALLOW_W];
         cfg[i].count              = fb_latch_q[i][synth_prog_pkg::COUNT_LSB +: synth_prog_pkg::COUNT_W];
         cfg[i].modulus_select_bit = fb_latch_q[i][synth_prog_pkg::MODULUS_POS];
         cfg[i].sleep_request_bit  = fb_latch_q[i][synth_prog_pkg::SLEEP_POS];
      end
   end

   // Counter reset mode: both view bits and the loop's own lock bit set
   logic both_view;
   logic [NL-1:0] cnt_reset;

   always_comb begin
      both_view = cfg[synth_prog_pkg::FIRST_LOOP].divider_view_bit &
                  cfg[synth_prog_pkg::SECOND_LOOP].divider_view_bit;
      for (int i = 0; i < NL; i++) begin
         cnt_reset[i] = both_view & cfg[i].lock_indicate_bit;
      end
   end

   // ---------------------------------------------------------------
   // Per-loop dividers, phase detector and power-down
   // ---------------------------------------------------------------
   logic [NL-1:0] ref_pulse;
   logic [NL-1:0] fb_pulse;
   logic [NL-1:0] lock_ok;
   logic [NL-1:0] pd_state;
   synth_prog_pkg::pump_ctl_t pump [NL];

   for (genvar g = 0; g < NL; g++) begin : g_loop
      logic [synth_prog_pkg::REF_RATIO_W-1:0] ref_cnt_q;
      logic [synth_prog_pkg::REF_RATIO_W-1:0] ref_cnt_d;
      logic [synth_prog_pkg::TOTAL_W-1:0]     fb_cnt_q;
      logic [synth_prog_pkg::TOTAL_W-1:0]     fb_cnt_d;
      logic [synth_prog_pkg::TOTAL_W-1:0]     fb_total;
      logic                                   ref_pls_q;
      logic                                   ref_pls_d;
      logic                                   fb_pls_q;
      logic                                   fb_pls_d;
      logic                                   up_q;
      logic                                   up_d;
      logic                                   dn_q;
      logic                                   dn_d;
      logic                                   pd_q;
      logic                                   pd_d;
      logic                                   hold;
      logic                                   ref_ev;
      logic                                   fb_ev;

      always_comb begin
         // Modulus times programmable count plus swallow count
         if (cfg[g].modulus_select_bit) begin
            fb_total = (synth_prog_pkg::TOTAL_W)'({cfg[g].count, synth_prog_pkg::MOD_HIGH_SHIFT'(0)})
                       + (synth_prog_pkg::TOTAL_W)'(cfg[g].swallow);
         end else begin
            fb_total = (synth_prog_pkg::TOTAL_W)'({cfg[g].count, synth_prog_pkg::MOD_LOW_SHIFT'(0)})
                       + (synth_prog_pkg::TOTAL_W)'(cfg[g].swallow);
         end
         hold = pd_q | cnt_reset[g];

         // Power-down: immediate with hiz set, otherwise once the pump idles
         pd_d = pd_q;
         if (!cfg[g].sleep_request_bit) begin
            pd_d = 1'b0;
         end else if (cfg[g].pump_hiz_bit) begin
            pd_d = 1'b1;
         end else if (!up_q && !dn_q) begin
            pd_d = 1'b1;
         end

         // Held counters sit at their load value, so release restarts both
         // dividers on the same cycle and they stay aligned
         ref_cnt_d = ref_cnt_q;
         ref_pls_d = 1'b0;
         fb_cnt_d  = fb_cnt_q;
         fb_pls_d  = 1'b0;
         if (hold) begin
            ref_cnt_d = cfg[g].ref_ratio;
            fb_cnt_d  = fb_total;
         end else begin
            if (osc_rise) begin
               if (ref_cnt_q <= (synth_prog_pkg::REF_RATIO_W)'(1)) begin
                  ref_cnt_d = cfg[g].ref_ratio;
                  ref_pls_d = 1'b1;
               end else begin
                  ref_cnt_d = ref_cnt_q - (synth_prog_pkg::REF_RATIO_W)'(1);
               end
            end
            if (fb_rise[g]) begin
               if (fb_cnt_q <= (synth_prog_pkg::TOTAL_W)'(1)) begin
                  fb_cnt_d = fb_total;
                  fb_pls_d = 1'b1;
               end else begin
                  fb_cnt_d = fb_cnt_q - (synth_prog_pkg::TOTAL_W)'(1);
               end
            end
         end

         // Phase-frequency detector; polarity swaps which edge pumps up
         ref_ev = cfg[g].phase_polarity_bit ? ref_pls_q : fb_pls_q;
         fb_ev  = cfg[g].phase_polarity_bit ? fb_pls_q : ref_pls_q;
         up_d   = up_q | ref_ev;
         dn_d   = dn_q | fb_ev;
         if (hold || (up_d && dn_d)) begin
            up_d = 1'b0;
            dn_d = 1'b0;
         end
      end

      always_ff @(posedge i_mclk or negedge i_nrst) begin
         if (!i_nrst) begin
            ref_cnt_q <= '0;
            fb_cnt_q  <= '0;
            ref_pls_q <= 1'b0;
            fb_pls_q  <= 1'b0;
            up_q      <= 1'b0;
            dn_q      <= 1'b0;
            pd_q      <= 1'b0;
         end else begin
            ref_cnt_q <= ref_cnt_d;
            fb_cnt_q  <= fb_cnt_d;
            ref_pls_q <= ref_pls_d;
            fb_pls_q  <= fb_pls_d;
            up_q      <= up_d;
            dn_q      <= dn_d;
            pd_q      <= pd_d;
         end
      end

      assign ref_pulse[g]        = ref_pls_q;
      assign fb_pulse[g]         = fb_pls_q;
      assign lock_ok[g]          = ~up_q & ~dn_q & ~pd_q;
      assign pd_state[g]         = pd_q;
      assign pump[g].pump_up     = up_q;
      assign pump[g].pump_dn     = dn_q;
      assign pump[g].pump_hiz    = cfg[g].pump_hiz_bit | cnt_reset[g] | pd_q;
      assign pump[g].pump_high   = cfg[g].pump_level_bit;
      assign pump[g].modulus_128 = cfg[g].modulus_select_bit;
      assign pump[g].power_down  = pd_q;
   end

   // ---------------------------------------------------------------
   // Shared status pin
   // ---------------------------------------------------------------
   synth_prog_pkg::status_drive_t drive_q;
   synth_prog_pkg::status_drive_t drive_d;
   logic                          status_q;
   logic                          status_d;
   logic [3:0]                    status_sel;
   logic                          quick_settle;

   always_comb begin
      status_sel = {cfg[synth_prog_pkg::FIRST_LOOP].lock_indicate_bit,
                    cfg[synth_prog_pkg::SECOND_LOOP].lock_indicate_bit,
                    cfg[synth_prog_pkg::FIRST_LOOP].divider_view_bit,
                    cfg[synth_prog_pkg::SECOND_LOOP].divider_view_bit};
      quick_settle = cfg[synth_prog_pkg::FIRST_LOOP].pump_level_bit |
                     cfg[synth_prog_pkg::SECOND_LOOP].pump_level_bit;
      drive_d  = synth_prog_pkg::STATUS_DRIVE;
      status_d = 1'b0;
      unique casez (status_sel)
         4'b0000: status_d = 1'b0;
         4'b0100: status_d = lock_ok[synth_prog_pkg::SECOND_LOOP];
         4'b1000: status_d = lock_ok[synth_prog_pkg::FIRST_LOOP];
         4'b1100: status_d = &lock_ok;
         4'b?001: status_d = ref_pulse[synth_prog_pkg::SECOND_LOOP];
         4'b?010: status_d = ref_pulse[synth_prog_pkg::FIRST_LOOP];
         4'b?101: status_d = fb_pulse[synth_prog_pkg::SECOND_LOOP];
         4'b?110: status_d = fb_pulse[synth_prog_pkg::FIRST_LOOP];
         4'b0011: begin
            // Pin grounds the extra damping resistor only while pumping high
            status_d = 1'b0;
            drive_d  = quick_settle ? synth_prog_pkg::STATUS_DRIVE : synth_prog_pkg::STATUS_RELEASE;
         end
         default: status_d = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         drive_q  <= synth_prog_pkg::STATUS_DRIVE;
         status_q <= 1'b0;
      end else begin
         drive_q  <= drive_d;
         status_q <= status_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         o_pump_up[i]     = pump[i].pump_up;
         o_pump_dn[i]     = pump[i].pump_dn;
         o_pump_hiz[i]    = pump[i].pump_hiz;
         o_pump_high[i]   = pump[i].pump_high;
         o_modulus_128[i] = pump[i].modulus_128;
         o_power_down[i]  = pump[i].power_down;
      end
   end

   // Oscillator stays alive until both loops are asleep
   assign o_osc_enable         = ~(&pd_state);
   assign o_shared_status_pin  = status_q;
   assign o_shared_status_oe_n = (drive_q == synth_prog_pkg::STATUS_RELEASE);

endmodule

// ===== hdl/pin_sync.sv
// Two-flop synchroniser with rising edge detect for one asynchronous pin
`timescale 1ns/1ps
module pin_sync (
   input  wire logic i_mclk,
   input  wire logic i_nrst,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;
   logic prev_q;
   logic prev_d;

   always_comb begin
      meta_d = i_pin;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Edge is taken between two settled stages only
   assign o_level = sync_q;
   assign o_rise  = sync_q & ~prev_q;

endmodule

// ===== hdl/synth_prog_pkg.sv
// Constants, field layout and carrier types of the dual-loop serial programming block
package synth_prog_pkg;

   // ---------------------------------------------------------------
   // Serial word layout
   // ---------------------------------------------------------------
   localparam int WORD_W      = 22;
   localparam int SEL_W       = 2;
   localparam int SEL_HI_POS  = 1;
   localparam int SEL_LO_POS  = 0;
   localparam int DATA_W      = 20;
   localparam int DATA_LSB    = 2;
   localparam int NUM_LOOPS   = 2;
   localparam int FIRST_LOOP  = 0;
   localparam int SECOND_LOOP = 1;

   // Latch select codes (high select bit, low select bit)
   localparam logic [1:0] SEL_SECOND_REF = 2'h0;
   localparam logic [1:0] SEL_FIRST_REF  = 2'h1;
   localparam logic [1:0] SEL_SECOND_FB  = 2'h2;
   localparam logic [1:0] SEL_FIRST_FB   = 2'h3;

   // ---------------------------------------------------------------
   // Reference latch fields, positions within the 20 data bits
   // ---------------------------------------------------------------
   localparam int REF_RATIO_LSB = 0;
   localparam int REF_RATIO_W   = 15;
   localparam int POLARITY_POS  = 15;
   localparam int LEVEL_POS     = 16;
   localparam int HIZ_POS       = 17;
   localparam int LOCK_SEL_POS  = 18;
   localparam int VIEW_SEL_POS  = 19;

   // ---------------------------------------------------------------
   // Feedback latch fields, positions within the 20 data bits
   // ---------------------------------------------------------------
   localparam int SWALLOW_LSB = 0;
   localparam int SWALLOW_W   = 7;
   localparam int COUNT_LSB   = 7;
   localparam int COUNT_W     = 11;
   localparam int MODULUS_POS = 18;
   localparam int SLEEP_POS   = 19;

   // Prescaler modulus as a shift: 64 or 128
   localparam int MOD_LOW_SHIFT  = 6;
   localparam int MOD_HIGH_SHIFT = 7;
   localparam int TOTAL_W        = 18;

   localparam logic [DATA_W-1:0] LATCH_RESET = 20'h0_0000;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [REF_RATIO_W-1:0] ref_ratio;
      logic                   phase_polarity_bit;
      logic                   pump_level_bit;
      logic                   pump_hiz_bit;
      logic                   lock_indicate_bit;
      logic                   divider_view_bit;
      logic [SWALLOW_W-1:0]   swallow;
      logic [COUNT_W-1:0]     count;
      logic                   modulus_select_bit;
      logic                   sleep_request_bit;
   } loop_cfg_t;

   typedef struct packed {
      logic pump_up;
      logic pump_dn;
      logic pump_hiz;
      logic pump_high;
      logic modulus_128;
      logic power_down;
   } pump_ctl_t;

   typedef enum logic [1:0] {
      STATUS_DRIVE,
      STATUS_RELEASE
   } status_drive_t;

endpackage

// ===== testbench/dual_pll_serial_program_latches_bench.sv
// Self-checking bench of the dual-loop serial programming block
`timescale 1ns/1ps
module dual_pll_serial_program_latches_bench;
   logic       clk  = 1'b0;
   logic       nrst = 1'b0;
   logic       osc  = 1'b0;
   logic [1:0] fb   = 2'h0;
   logic [1:0] up, dn, hiz, high, m128, pd, lvl, hz, md, sl, lk, vw;
   logic       sclk, sdat, strb, osc_en, pin, oe_n;
   int         bad_count = 0;
   int         compares  = 0;
   int         cyc       = 0;
   always #10 clk = ~clk;
   dual_pll_serial_program_latches dut (.i_mclk(clk), .i_nrst(nrst), .i_serial_clk(sclk),
      .i_serial_data(sdat), .i_load_strobe(strb), .i_ref_osc(osc), .i_fb_in(fb), .o_pump_up(up),
      .o_pump_dn(dn), .o_pump_hiz(hiz), .o_pump_high(high), .o_modulus_128(m128), .o_power_down(pd),
      .o_osc_enable(osc_en), .o_shared_status_pin(pin), .o_shared_status_oe_n(oe_n));
   serial_host host (.o_serial_clk(sclk), .o_serial_data(sdat), .o_load_strobe(strb));
   // ----
   // Divider inputs and hang guard
   // ----
   always @(posedge clk) begin
      #2;
      osc <= cyc[2];
      fb  <= cyc[4:3];
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic send(input logic [19:0] d, input logic [1:0] sel, input logic load);
      @(posedge clk);
      #2;
      host.send_word({d, sel}, load);
      repeat (8) @(posedge clk);
      #2;
   endtask
   task automatic load_ref(input int k, input logic l, input logic h, input logic c, input logic v);
      logic [14:0] r;
      logic        pol;
      r = 15'(3 + $urandom % 32765);
      pol = 1'($urandom);
      lvl[k] = l;
      hz[k] = h;
      lk[k] = c;
      vw[k] = v;
      send({v, c, h, l, pol, r}, {1'b0, k == 0}, 1'b1);
   endtask
   task automatic load_fb(input int k, input logic m, input logic s);
      logic [10:0] b;
      logic [6:0]  a;
      b = 11'(64 + $urandom % 1984);
      a = 7'($urandom % 64);
      md[k] = m;
      sl[k] = s;
      send({s, m, b, a}, {1'b1, k == 0}, 1'b1);
   endtask
   // Only asynchronous power-down is requested, so it follows sleep and hiz bits directly
   task automatic check_all();
      logic [1:0] p;
      logic [1:0] cr;
      p  = sl & hz;
      cr = (&vw) ? lk : 2'h0;
      chk(high, lvl, "pump level");
      chk(m128, md, "modulus");
      chk(pd, p, "power down");
      chk(hiz, hz | p | cr, "pump hiz");
      chk({1'b0, osc_en}, {1'b0, ~&p}, "osc enable");
      if ({lk, vw} == 4'h0) chk({pin, oe_n}, 2'h0, "status off");
      if (&vw) chk({pin & ~oe_n, oe_n}, {1'b0, lk == 2'h0 && lvl == 2'h0}, "status mode");
   endtask
   initial begin
      int n;
      void'($urandom(21));
      {lvl, hz, md, sl, lk, vw} = 12'h000;
      repeat (4) @(posedge clk);
      #2;
      nrst = 1'b1;
      check_all();
      repeat (12) begin
         load_ref($urandom % 2, 1'($urandom), 1'($urandom), 1'b0, 1'b0);
         load_fb($urandom % 2, 1'($urandom), 1'b0);
         check_all();
      end
      send(20'hf_ffff, 2'h3, 1'b0);
      check_all();
      for (int k = 0; k < 2; k++) begin
         load_ref(k, 1'b1, 1'b1, 1'b0, 1'b0);
         load_fb(k, 1'b0, 1'b1);
         check_all();
      end
      for (int k = 0; k < 2; k++) begin
         load_fb(k, 1'b1, 1'b0);
         check_all();
      end
      load_ref(0, 1'b0, 1'b0, 1'b0, 1'b1);
      load_ref(1, 1'b0, 1'b0, 1'b0, 1'b1);
      check_all();
      load_ref(0, 1'b1, 1'b0, 1'b0, 1'b1);
      check_all();
      load_ref(0, 1'b1, 1'b0, 1'b1, 1'b1);
      load_ref(1, 1'b0, 1'b0, 1'b1, 1'b1);
      check_all();
      // Ratio three loads while the first loop is held, so the reference count starts from three on release
      send(20'hd_0003, 2'h1, 1'b1);
      load_ref(1, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge pin);
      #1;
      n = cyc;
      @(posedge pin);
      #1;
      compares++;
      if (cyc - n != 3 * 8) begin
         bad_count++;
         $display("unexpected at %0t: reference pulse spacing %0d", $time, cyc - n);
      end
      load_ref(0, 1'b0, 1'b0, 1'b0, 1'b0);
      check_all();
      report_and_stop();
   end
endmodule

// ===== testbench/serial_host.sv
// Host controller model driving the three-wire programming link
`timescale 1ns/1ps
module serial_host (
   output logic o_serial_clk,
   output logic o_serial_data,
   output logic o_load_strobe
);
   initial begin
      o_serial_clk  = 1'b0;
      o_serial_data = 1'b0;
      o_load_strobe = 1'b0;
   end
   // Link clock rests low between words; data flips after each rise so a stale bit is never valid
   task automatic send_word(input logic [21:0] w, input logic load);
      for (int i = 21; i >= 0; i--) begin
         o_serial_data = w[i];
         #80;
         o_serial_clk = 1'b1;
         #40;
         o_serial_data = ~w[i];
         #40;
         o_serial_clk = 1'b0;
      end
      #80;
      o_load_strobe = load;
      #80;
      o_load_strobe = 1'b0;
   endtask
endmodule

// ===== testbench/synth_prog_properties.sv
// Port-level checks of the dual-loop serial programming block
`timescale 1ns/1ps
module synth_prog_properties (
   input  wire logic       i_mclk,
   input  wire logic       i_nrst,
   input  wire logic       i_load_strobe,
   input  wire logic [1:0] o_pump_up,
   input  wire logic [1:0] o_pump_dn,
   input  wire logic [1:0] o_pump_hiz,
   input  wire logic [1:0] o_pump_high,
   input  wire logic [1:0] o_modulus_128,
   input  wire logic [1:0] o_power_down,
   input  wire logic       o_osc_enable,
   input  wire logic       o_shared_status_oe_n
);
   logic       seen_q;
   logic       seen_d;
   logic [3:0] age_q;
   logic [3:0] age_d;
   // Cycles since the raw strobe rose; saturates so old loads never look fresh
   always_comb begin
      seen_d = i_load_strobe;
      age_d  = (i_load_strobe && !seen_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
   end
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         seen_q <= 1'b0;
         age_q  <= 4'hf;
      end else begin
         seen_q <= seen_d;
         age_q  <= age_d;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   osc_off_a: assert property ((&o_power_down) |-> ##[0:2] !o_osc_enable)
      else $error("oscillator kept running with both loops down");
   osc_on_a: assert property (!(&o_power_down) |-> ##[0:2] o_osc_enable)
      else $error("oscillator stopped with a loop powered");
   hiz_down_a: assert property ((o_power_down & ~o_pump_hiz) == 2'h0)
      else $error("powered down loop pump not high impedance");
   level_hold_a: assert property ($changed(o_pump_high) |-> age_q <= 4'h9)
      else $error("pump level changed without a load");
   modulus_hold_a: assert property ($changed(o_modulus_128) |-> age_q <= 4'h9)
      else $error("modulus changed without a load");
   one_latch_a: assert property (!($changed(o_pump_high) && $changed(o_modulus_128)))
      else $error("two latch kinds changed at once");
   one_loop_a: assert property ($changed(o_pump_high) |-> $onehot(o_pump_high ^ $past(o_pump_high)))
      else $error("both loops changed level at once");
   pump_clear_a: assert property ((o_pump_up & o_pump_dn) == 2'h0)
      else $error("pump up and down held together");
   down_quiet_a: assert property ((o_power_down & $past(o_power_down) & (o_pump_up | o_pump_dn)) == 2'h0)
      else $error("powered down loop still pumping");
   settle_drive_a: assert property ((|o_pump_high) [*3] |-> !o_shared_status_oe_n)
      else $error("status pin released with a high pump level");
endmodule
bind dual_pll_serial_program_latches synth_prog_properties chk (.i_mclk, .i_nrst, .i_load_strobe,
   .o_pump_up, .o_pump_dn, .o_pump_hiz, .o_pump_high, .o_modulus_128, .o_power_down, .o_osc_enable,
   .o_shared_status_oe_n);
